// *** rtl/rtcf_core.sv ***
// Status flags, control registers, divider and second/minute counters
//
// Functional notes
// - Pulse mode delays seconds increment about 92us
// - Seconds write clears divider; in pulse mode drives interrupt low
// - Flag register at Fh, 10h after halt
// - Threshold select bit drives detector threshold choice
// - Supply low sets sticky flag, stops monitoring
// - Writing 0 clears supply flag; 1 ignored
// - Free scratch bit, cleared on halt
// - Halt flag sets on stop, stays set
// - Halt detection only while chip enable low
// - Halt clears control registers, irq, enables clock
// - Writing 0 clears halt flag, rearms detection
// - Slow clock out gated by enables and pin
// - Periodic flag mirrors periodic interrupt pin drive
// - Level mode: writing 0 releases pin
// - Alarm flag about 61us after match, with pin
// - Writing 0 to alarm flag releases pin
// - Disabled alarm reads its flag as zero
// - Seconds, minutes BCD 00-59 with carry
// - Hour rollover carries into day counters
// - Seconds at 0h, top bit zero
// - Minutes at 1h, top bit zero
// - Level interrupt per period, with seconds increment
`timescale 1ns/10ps
`default_nettype none
module rtcf_core (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       xtal_clk_i,
    input  wire logic       ce_i,
    input  wire logic       osc_stopped_i,
    input  wire logic       supply_low_i,
    input  wire logic       clk_out_gate_pin_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic       weekly_alarm_match_i,
    input  wire logic       daily_alarm_match_i,
    input  wire logic       hour_at_last_i,
    input  wire logic       month_last_day_i,
    output logic      [7:0] reg_rdata_o,
    output logic            irq_out_n_o,
    output logic            slow_clock_out_o,
    output logic            supply_threshold_sel_o,
    output logic            hour_24_mode_o,
    output logic            minute_carry_o,
    output logic            day_carry_o
);
    import rtcf_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [4:0]       sync1_ff;
    logic [4:0]       sync2_ff;
    logic             xtal_prev_ff;
    logic [DIV_W-1:0] div_ff;
    logic             pend_ff;
    logic [DLY_W-1:0] dly_ff;
    logic [7:0]       ctrl1_ff;
    logic [6:0]       osc_adj_ff;
    logic             thr_ff;
    logic             vlow_ff;
    logic             scratch_ff;
    logic             halt_ff;
    logic             clkd_a_ff;
    logic             level_ff;
    logic             pirq_ff;
    logic [1:0]       alm_pend_ff;
    logic [DLY_W-1:0] alm_dly_ff [2];
    logic [1:0]       alm_flag_ff;
    logic [7:0]       reg_rdata_ff;
    logic             irq_out_n_ff;
    logic             slow_clk_ff;
    logic             min_carry_ff;
    logic             day_carry_ff;

    // ------------------------------------------------------------------
    // Pin synchronisers: xtal, ce, osc stop, supply low, gate
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_ff     <= 5'h00;
            sync2_ff     <= 5'h00;
            xtal_prev_ff <= 1'b0;
        end else begin
            sync1_ff     <= {clk_out_gate_pin_i, supply_low_i,
                             osc_stopped_i, ce_i, xtal_clk_i};
            sync2_ff     <= sync1_ff;
            xtal_prev_ff <= sync2_ff[0];
        end
    end

    wire xtal_s  = sync2_ff[0];
    wire ce_s    = sync2_ff[1];
    wire stop_s  = sync2_ff[2];
    wire vlow_s  = sync2_ff[3];
    wire gate_s  = sync2_ff[4];
    wire tick    = xtal_s & ~xtal_prev_ff;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    wire sec_wr   = reg_wr_i & (reg_addr_i == ADDR_SECONDS);
    wire min_wr   = reg_wr_i & (reg_addr_i == ADDR_MINUTES);
    wire adj_wr   = reg_wr_i & (reg_addr_i == ADDR_OSC_ADJ);
    wire c1_wr    = reg_wr_i & (reg_addr_i == ADDR_CTRL1);
    wire flag_wr  = reg_wr_i & (reg_addr_i == ADDR_FLAGS);
    wire [7:0] wclr = {8{flag_wr}} & ~reg_wdata_i;

    wire rtcf_ct_mode_t ct_mode = rtcf_ct_mode_t'(ctrl1_ff[2:0]);
    wire pulse_mode = (ct_mode == CT_P2HZ) | (ct_mode == CT_P1HZ);
    wire level_mode = ctrl1_ff[2];
    wire [1:0] alm_en = {ctrl1_ff[C1_WEN], ctrl1_ff[C1_DEN]};

    // ------------------------------------------------------------------
    // Halt and supply detection
    // ------------------------------------------------------------------
    wire halt_set = ~halt_ff & ~ce_s & stop_s;
    wire vlow_set = ~vlow_ff & vlow_s;
    wire nxt_halt = halt_set |
                    (halt_ff & ~wclr[FLG_HALT]);
    wire nxt_vlow = ~halt_set & (vlow_set |
                    (vlow_ff & ~wclr[FLG_VLOW]));

    // ------------------------------------------------------------------
    // Sub-second divider and delayed second increment
    // ------------------------------------------------------------------
    wire [DIV_W-1:0] nxt_div = sec_wr ? {DIV_W{1'b0}} :
                               tick   ? DIV_W'(div_ff + 1'b1) : div_ff;
    wire sec_edge  = tick & (&div_ff) & ~sec_wr;
    wire dly_done  = pend_ff & tick &
                     (dly_ff == DLY_W'(SEC_DELAY_TICKS - 1));
    wire sec_inc   = ~sec_wr & ((sec_edge & ~pulse_mode) |
                     dly_done);

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            div_ff  <= {DIV_W{1'b0}};
            pend_ff <= 1'b0;
            dly_ff  <= {DLY_W{1'b0}};
        end else begin
            div_ff  <= nxt_div;
            pend_ff <= ~sec_wr & ((sec_edge & pulse_mode) |
                       (pend_ff & ~dly_done));
            dly_ff  <= sec_edge ? {DLY_W{1'b0}} :
                       (tick ? DLY_W'(dly_ff + 1'b1) : dly_ff);
        end
    end

    // ------------------------------------------------------------------
    // Seconds and minutes counters
    // ------------------------------------------------------------------
    logic [6:0] sec_count;
    logic [6:0] min_count;
    logic       sec_wrap;
    logic       min_wrap;

    rtcf_bcd60 u_sec (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .load_i     (sec_wr),
        .load_val_i (reg_wdata_i[6:0]),
        .inc_i      (sec_inc),
        .count_o    (sec_count),
        .wrap_o     (sec_wrap)
    );

    rtcf_bcd60 u_min (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .load_i     (min_wr),
        .load_val_i (reg_wdata_i[6:0]),
        .inc_i      (sec_wrap),
        .count_o    (min_count),
        .wrap_o     (min_wrap)
    );

    wire day_carry = min_wrap & hour_at_last_i;

    // ------------------------------------------------------------------
    // Periodic interrupt
    // ------------------------------------------------------------------
    function automatic logic period_hit(input rtcf_ct_mode_t m,
                                        input logic s, input logic h,
                                        input logic mo);
        logic r;
        r = 1'b0;
        unique case (m)
            CT_L_SEC:   r = 1'b1;
            CT_L_MIN:   r = s;
            CT_L_HOUR:  r = h;
            CT_L_MONTH: r = mo;
            CT_OFF, CT_LOW, CT_P2HZ, CT_P1HZ: r = 1'b0;
        endcase
        return r;
    endfunction

    wire level_set = sec_inc & level_mode & period_hit(ct_mode,
                     sec_wrap, min_wrap,
                     day_carry & month_last_day_i);
    wire nxt_level = ~halt_set & level_mode & (level_set |
                     (level_ff & ~wclr[FLG_PIRQ]));
    wire nxt_pirq  = ~halt_set & ((ct_mode == CT_LOW) |
                     ((ct_mode == CT_P1HZ) & ~nxt_div[DIV_1HZ_BIT]) |
                     ((ct_mode == CT_P2HZ) & ~nxt_div[DIV_2HZ_BIT]) |
                     nxt_level);

    // ------------------------------------------------------------------
    // Alarm flags, set after a short crystal delay
    // ------------------------------------------------------------------
    wire [1:0] alm_match = {weekly_alarm_match_i, daily_alarm_match_i} &
                           alm_en;
    wire [1:0] alm_clr   = {wclr[FLG_WALM], wclr[FLG_DALM]};
    logic [1:0] alm_set;
    logic [1:0] nxt_alm_flag;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            alm_set[i] = alm_pend_ff[i] & tick &
                         (alm_dly_ff[i] ==
                          DLY_W'(ALARM_DELAY_TICKS - 1));
            nxt_alm_flag[i] = ~halt_set & (alm_set[i] |
                              (alm_flag_ff[i] & ~alm_clr[i]));
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            alm_pend_ff <= 2'h0;
            alm_dly_ff  <= '{default: '0};
            alm_flag_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                alm_pend_ff[i] <= ~halt_set & (alm_match[i] |
                                  (alm_pend_ff[i] & ~alm_set[i]));
                alm_dly_ff[i]  <= alm_match[i] ? {DLY_W{1'b0}} :
                    (tick ? DLY_W'(alm_dly_ff[i] + 1'b1) : alm_dly_ff[i]);
            end
            alm_flag_ff <= nxt_alm_flag;
        end
    end

    // Pin drive uses next flag values so flag and pin move together
    wire nxt_irq = nxt_pirq |
                   (|(nxt_alm_flag & alm_en & {2{~halt_set}}));

    // ------------------------------------------------------------------
    // Control and flag registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl1_ff   <= CTRL1_RESET;
            osc_adj_ff <= OSC_ADJ_RESET;
            thr_ff     <= FLAGS_RESET[FLG_THR];
            scratch_ff <= FLAGS_RESET[FLG_SCR];
            clkd_a_ff  <= FLAGS_RESET[FLG_CLKD];
            halt_ff    <= FLAGS_RESET[FLG_HALT];
            vlow_ff    <= FLAGS_RESET[FLG_VLOW];
            level_ff   <= 1'b0;
            pirq_ff    <= 1'b0;
        end else begin
            if (halt_set) begin
                ctrl1_ff   <= CTRL1_RESET;
                osc_adj_ff <= OSC_ADJ_RESET;
                thr_ff     <= 1'b0;
                scratch_ff <= 1'b0;
                clkd_a_ff  <= 1'b0;
            end else begin
                if (c1_wr) begin
                    ctrl1_ff <= reg_wdata_i;
                end
                if (adj_wr) begin
                    osc_adj_ff <= reg_wdata_i[6:0];
                end
                if (flag_wr) begin
                    thr_ff     <= reg_wdata_i[FLG_THR];
                    scratch_ff <= reg_wdata_i[FLG_SCR];
                    clkd_a_ff  <= reg_wdata_i[FLG_CLKD];
                end
            end
            halt_ff  <= nxt_halt;
            vlow_ff  <= nxt_vlow;
            level_ff <= nxt_level;
            pirq_ff  <= nxt_pirq;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] flag_val = {thr_ff, vlow_ff, scratch_ff, halt_ff,
                           clkd_a_ff, pirq_ff,
                           alm_flag_ff & alm_en};
    wire [7:0] rd_val =
        (reg_addr_i == ADDR_SECONDS) ? {1'b0, sec_count} :
        (reg_addr_i == ADDR_MINUTES) ? {1'b0, min_count} :
        (reg_addr_i == ADDR_OSC_ADJ) ? {1'b0, osc_adj_ff} :
        (reg_addr_i == ADDR_CTRL1)   ? ctrl1_ff :
        (reg_addr_i == ADDR_FLAGS)   ? flag_val : 8'h00;

    wire clk_en = (~clkd_a_ff | ~ctrl1_ff[C1_CLKD]) & gate_s;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_ff <= 8'h00;
            irq_out_n_ff <= 1'b1;
            slow_clk_ff  <= 1'b0;
            min_carry_ff <= 1'b0;
            day_carry_ff <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_ff <= rd_val;
            end
            irq_out_n_ff <= ~nxt_irq;
            slow_clk_ff  <= xtal_s & clk_en;
            min_carry_ff <= min_wrap;
            day_carry_ff <= day_carry;
        end
    end

    assign reg_rdata_o            = reg_rdata_ff;
    assign irq_out_n_o            = irq_out_n_ff;
    assign slow_clock_out_o       = slow_clk_ff;
    assign supply_threshold_sel_o = thr_ff;
    assign hour_24_mode_o         = ctrl1_ff[C1_H24];
    assign minute_carry_o         = min_carry_ff;
    assign day_carry_o            = day_carry_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    AST_SEC_DELAY: assert property (
        (sec_edge && pulse_mode) |-> !sec_inc ##1 pend_ff)
        else $error("pulse mode second did not wait");
    AST_SEC_WR_DIV: assert property (
        sec_wr |=> (div_ff == '0) && !pend_ff)
        else $error("seconds write left divider running");
    AST_SEC_WR_IRQ: assert property (
        (sec_wr && pulse_mode && !halt_set) |=> !irq_out_n_o)
        else $error("seconds write did not drive irq low");
    AST_HALT_READ: assert property (
        halt_set |=> (flag_val == FLAGS_RESET))
        else $error("flag register wrong after halt");
    AST_VLOW_HOLD: assert property (
        (vlow_ff && !wclr[FLG_VLOW] && !halt_set) |=> vlow_ff)
        else $error("supply flag dropped");
    AST_HALT_STICKY: assert property (
        (halt_ff && !wclr[FLG_HALT]) |=> halt_ff)
        else $error("halt flag dropped without write");
    AST_CE_IDLE: assert property (
        (!halt_ff && ce_s) |=> !halt_ff)
        else $error("halt detected with chip enable high");
    AST_HALT_CLEAR: assert property (
        halt_set |=> (ctrl1_ff == CTRL1_RESET) && (osc_adj_ff == '0)
                     && irq_out_n_o && halt_ff)
        else $error("halt did not clear control state");
    AST_CLK_GATE: assert property (
        !gate_s |=> !slow_clock_out_o)
        else $error("slow clock ran with gate low");
    AST_PIRQ_PIN: assert property (
        pirq_ff |-> !irq_out_n_o)
        else $error("periodic flag set but pin released");
    AST_ALM_PIN: assert property (
        ($rose(alm_flag_ff[0]) && alm_en[0]) |-> !irq_out_n_o)
        else $error("alarm flag and pin not together");
    AST_ALM_READ: assert property (
        !alm_en[0] |-> !flag_val[FLG_DALM])
        else $error("disabled alarm flag reads one");
    AST_MIN_CARRY: assert property (
        (sec_wrap && !min_wr) |=> (min_count != $past(min_count)))
        else $error("seconds wrap did not carry");

    COV_HALT:  cover property (halt_set);
    COV_LEVEL: cover property (level_set);
    COV_ALARM: cover property (alm_set[0]);
    COV_WRAP:  cover property (sec_wrap);
endmodule
`default_nettype wire

// *** rtl/rtcf_pkg.sv ***
// Constants and types shared by the status-flag and time-counter block
package rtcf_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_MINUTES = 4'h1;
    localparam logic [3:0] ADDR_OSC_ADJ = 4'h7;
    localparam logic [3:0] ADDR_CTRL1   = 4'he;
    localparam logic [3:0] ADDR_FLAGS   = 4'hf;

    // ------------------------------------------------------------------
    // Field positions of the status flag register
    // ------------------------------------------------------------------
    localparam int FLG_THR  = 7;
    localparam int FLG_VLOW = 6;
    localparam int FLG_SCR  = 5;
    localparam int FLG_HALT = 4;
    localparam int FLG_CLKD = 3;
    localparam int FLG_PIRQ = 2;
    localparam int FLG_WALM = 1;
    localparam int FLG_DALM = 0;

    // ------------------------------------------------------------------
    // Field positions of the first control register
    // ------------------------------------------------------------------
    localparam int C1_WEN  = 7;
    localparam int C1_DEN  = 6;
    localparam int C1_H24  = 5;
    localparam int C1_CLKD = 4;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET   = 8'h10;
    localparam logic [7:0] CTRL1_RESET   = 8'h00;
    localparam logic [6:0] OSC_ADJ_RESET = 7'h00;
    localparam logic [6:0] BCD_RESET     = 7'h00;

    // ------------------------------------------------------------------
    // Crystal timing, counted in crystal edges (nearest whole edge)
    // ------------------------------------------------------------------
    localparam int XTAL_HZ           = 32768;
    localparam int SEC_DELAY_US      = 92;
    localparam int ALARM_DELAY_US    = 61;
    localparam int SEC_DELAY_TICKS   =
        (SEC_DELAY_US * XTAL_HZ + 500000) / 1000000;
    localparam int ALARM_DELAY_TICKS =
        (ALARM_DELAY_US * XTAL_HZ + 500000) / 1000000;
    localparam int DLY_W             = 2;
    localparam int DIV_W             = 15;
    localparam int DIV_1HZ_BIT       = 14;
    localparam int DIV_2HZ_BIT       = 13;

    // ------------------------------------------------------------------
    // Periodic interrupt modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CT_OFF     = 3'b000,
        CT_LOW     = 3'b001,
        CT_P2HZ    = 3'b010,
        CT_P1HZ    = 3'b011,
        CT_L_SEC   = 3'b100,
        CT_L_MIN   = 3'b101,
        CT_L_HOUR  = 3'b110,
        CT_L_MONTH = 3'b111
    } rtcf_ct_mode_t;

endpackage

// *** rtl/rtcf_bcd60.sv ***
// BCD counter from 00 to 59 with load, used for seconds and minutes
`timescale 1ns/10ps
`default_nettype none
module rtcf_bcd60 (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       load_i,
    input  wire logic [6:0] load_val_i,
    input  wire logic       inc_i,
    output logic      [6:0] count_o,
    output logic            wrap_o
);
    import rtcf_pkg::*;

    logic [6:0] count_ff;
    logic [6:0] nxt_count;

    // ------------------------------------------------------------------
    // Next BCD value
    // ------------------------------------------------------------------
    function automatic logic [6:0] bcd60_next(input logic [6:0] v);
        logic [6:0] r;
        r = v;
        if (v == 7'h59) begin
            r = 7'h00;
        end else if (v[3:0] == 4'h9) begin
            r = {3'(v[6:4] + 3'h1), 4'h0};
        end else begin
            r = {v[6:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction

    // Load beats counting; wrap only on a real count
    assign wrap_o    = inc_i & ~load_i & (count_ff == 7'h59);
    assign nxt_count = load_i ? load_val_i :
                       inc_i  ? bcd60_next(count_ff) : count_ff;
    assign count_o   = count_ff;

    // Counter state
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            count_ff <= BCD_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule
`default_nettype wire

// *** testbench/rtcf_host.sv ***
// Host model driving the register port of the flag block
`timescale 1ns/10ps
`default_nettype none
module rtcf_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    // Idle bus at time zero
    initial begin
        addr_o  = 4'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    // One write strobe; stale lines inverted after
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i) #1;
        addr_o  = a;
        wdata_o = d; // Callers pass raw register bytes, not only time values
        wr_o    = 1'b1;
        @(posedge mclk_i) #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask
    // One read strobe; data taken the edge after
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i) #1;
        addr_o = a;
        rd_o   = 1'b1;
        @(posedge mclk_i) #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        d      = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the flag and time-counter block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rtcf_pkg::*;
    logic mclk = 0, rst = 1, xtal = 0, ce = 1, stop = 0, vlo = 0;
    logic gate = 1, wm = 0, dm = 0, wr, rd, irq_n, sclk, thr, h24;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    int fail_count = 0, cmp_count = 0;
    // System clock 5 ns, crystal 80 ns
    always #2.5 mclk = ~mclk;
    always #40 xtal = ~xtal;
    rtcf_host HOST (.mclk_i(mclk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    rtcf_core DUT (.mclk_i(mclk), .reset_i(rst), .xtal_clk_i(xtal),
        .ce_i(ce), .osc_stopped_i(stop), .supply_low_i(vlo),
        .clk_out_gate_pin_i(gate), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .weekly_alarm_match_i(wm), .daily_alarm_match_i(dm),
        .hour_at_last_i(1'b0), .month_last_day_i(1'b0),
        .reg_rdata_o(rdata), .irq_out_n_o(irq_n),
        .slow_clock_out_o(sclk), .supply_threshold_sel_o(thr),
        .hour_24_mode_o(h24), .minute_carry_o(), .day_carry_o());
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        HOST.rd(a, d);
        chk8(d, exp);
    endtask
    // Bounded wait for the interrupt pin level
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 400 && irq_n !== lvl; i++)
            @(posedge mclk) #1;
        chk1(irq_n, lvl);
        if (irq_n !== lvl) end_sim();
    endtask
    // Levels seen on the slow clock over 64 cycles
    task automatic sclk_chk(input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'b00;
        cyc(6);
        repeat (64) begin
            @(posedge mclk) #1;
            seen = seen | {sclk === 1'b1, sclk === 1'b0};
        end
        chk8({6'h00, seen}, {6'h00, exp});
    endtask
    task automatic t_flags;
        rchk(ADDR_FLAGS, FLAGS_RESET);
        chk1(irq_n, 1'b1);
        HOST.wr(ADDR_FLAGS, 8'hff);
        rchk(ADDR_FLAGS, 8'hb8);
        chk1(thr, 1'b1);
        HOST.wr(ADDR_FLAGS, 8'h20);
        rchk(ADDR_FLAGS, 8'h20);
    endtask
    task automatic t_halt;
        HOST.wr(ADDR_CTRL1, 8'hf0);
        chk1(h24, 1'b1);
        stop = 1'b1;
        cyc(12);
        rchk(ADDR_FLAGS, 8'h20);
        ce = 1'b0;
        cyc(12);
        stop = 1'b0;
        rchk(ADDR_CTRL1, 8'h00);
        chk1(h24, 1'b0);
        cyc(12);
        rchk(ADDR_FLAGS, 8'h10);
        HOST.wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_clk_supply;
        sclk_chk(2'b11);
        HOST.wr(ADDR_FLAGS, 8'h08);
        sclk_chk(2'b11);
        HOST.wr(ADDR_CTRL1, 8'h10);
        sclk_chk(2'b01);
        HOST.wr(ADDR_FLAGS, 8'h00);
        gate = 1'b0;
        sclk_chk(2'b01);
        vlo = 1'b1;
        cyc(8);
        vlo = 1'b0;
        cyc(8);
        HOST.wr(ADDR_FLAGS, 8'h40);
        rchk(ADDR_FLAGS, 8'h40);
        HOST.wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_time_pulse;
        HOST.wr(ADDR_CTRL1, 8'h20); // Hour format first
        HOST.wr(ADDR_SECONDS, 8'hd9);
        rchk(ADDR_SECONDS, 8'h59);
        HOST.wr(ADDR_MINUTES, 8'hd9);
        rchk(ADDR_MINUTES, 8'h59);
        HOST.wr(ADDR_CTRL1, 8'h23);
        HOST.wr(ADDR_SECONDS, 8'h30);
        wait_irq(1'b0);
        rchk(ADDR_FLAGS, 8'h04);
        HOST.wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_FLAGS, 8'h04);
        HOST.wr(ADDR_CTRL1, 8'h20);
        wait_irq(1'b1);
        rchk(ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_alarm;
        HOST.wr(ADDR_CTRL1, 8'ha0);
        wm = 1'b1;
        cyc(1);
        wm = 1'b0;
        wait_irq(1'b0);
        rchk(ADDR_FLAGS, 8'h02);
        HOST.wr(ADDR_FLAGS, 8'h02);
        rchk(ADDR_FLAGS, 8'h02);
        HOST.wr(ADDR_FLAGS, 8'h00);
        wait_irq(1'b1);
        dm = 1'b1;
        cyc(1);
        dm = 1'b0;
        cyc(80);
        chk1(irq_n, 1'b1);
        rchk(ADDR_FLAGS, 8'h00);
        HOST.wr(ADDR_CTRL1, 8'h60);
        dm = 1'b1;
        cyc(1);
        dm = 1'b0;
        wait_irq(1'b0);
        rchk(ADDR_FLAGS, 8'h01);
        HOST.wr(ADDR_CTRL1, 8'h20);
        rchk(ADDR_FLAGS, 8'h00);
        wait_irq(1'b1);
    endtask
    // Reset for six cycles, then the scenarios
    initial begin
        cyc(6);
        rst = 1'b0;
        t_flags();
        t_halt();
        t_clk_supply();
        t_time_pulse();
        t_alarm();
        end_sim();
    end
endmodule
`default_nettype wire
